//--- crbt_pkg.sv
// Package: register map, field positions and constants of the capture/reload timer
package crbt_pkg;

    // Avalon word offsets (byte address = 4 * index)
    localparam logic [3:0] CRBT_OFF_CTRL = 4'h0;
    localparam logic [3:0] CRBT_OFF_CLKCTL = 4'h1;
    localparam logic [3:0] CRBT_OFF_CNTL = 4'h2;
    localparam logic [3:0] CRBT_OFF_CNTH = 4'h3;
    localparam logic [3:0] CRBT_OFF_CAPL = 4'h4;
    localparam logic [3:0] CRBT_OFF_CAPH = 4'h5;
    localparam logic [3:0] CRBT_OFF_IRQ_STAT = 4'h6;
    localparam logic [3:0] CRBT_OFF_IRQ_MASK = 4'h7;

    // Control register bit positions
    localparam int CRBT_B_CPRL = 0;
    localparam int CRBT_B_CSRC = 1;
    localparam int CRBT_B_RUN = 2;
    localparam int CRBT_B_EXEN = 3;
    localparam int CRBT_B_TXSEL = 4;
    localparam int CRBT_B_RXSEL = 5;
    localparam int CRBT_B_EXF = 6;
    localparam int CRBT_B_OVF = 7;
    // Clock control register: divide select
    localparam int CRBT_B_DIV = 5;

    // Interrupt status bits
    localparam int CRBT_I_OVF = 0;
    localparam int CRBT_I_EXF = 1;
    localparam int CRBT_I_BAUD = 2;

    localparam logic [7:0] CRBT_RST_BYTE = 8'h00;
    localparam logic [2:0] CRBT_RST_IRQ = 3'h0;
    localparam logic [15:0] CRBT_CNT_MAX = 16'hffff;
    localparam logic [3:0] CRBT_DIV12_LAST = 4'hb;

    typedef enum logic [1:0] {
        CRBT_OFF,
        CRBT_CAPTURE,
        CRBT_RELOAD,
        CRBT_BAUD
    } crbt_mode_t;

    // Avalon-MM slave request
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } crbt_avreq_t;

    // Baud and trigger events toward UART and ADC
    typedef struct packed {
        logic rx_baud;
        logic tx_baud;
        logic adc_start;
    } crbt_evt_t;

endpackage : crbt_pkg

//--- crbt_timer.sv
// Capture / auto-reload / baud generator 16-bit timer with Avalon-MM slave
//
// Functional notes
// RQ1: Sixteen-bit up-counter from two byte halves
// RQ2: Source bit selects divided clock or pin
// RQ3: Overflow event offered as converter start trigger
// RQ4: Mode decode: off, baud, capture, reload
// RQ5: Capture when select and run bits set
// RQ6: Strobe edge captures count, sets external flag
// RQ7: Strobe ignored while external enable clear
// RQ8: Wrap sets overflow flag in capture/reload
// RQ9: Reload mode loads capture value on overflow
// RQ10: Reload mode strobe edge also reloads
// RQ11: Run bit starts and stops counting
// RQ12: Baud mode reloads, no flag, drives shift clock
// RQ13: Receive and transmit baud select independently
// RQ14: Any baud select forces reload behaviour
// RQ15: Baud mode internal source divides clock by two
// RQ16: Baud mode external source counts pin edges
// RQ17: Baud mode strobe edge sets external flag
// RQ18: Software uses baud mode only in UART modes 1/3
// RQ19: Pins synchronised, falling edge gives one pulse
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module crbt_timer (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Avalon-MM slave
    input wire crbt_pkg::crbt_avreq_t av_req_i,
    output logic [31:0] av_readdata_o,
    output logic av_waitrequest_o,
    // External pins
    input wire logic ext_count_pin_i,
    input wire logic ext_strobe_pin_i,
    // Events and interrupt
    output crbt_pkg::crbt_evt_t evt_o,
    output logic irq_o
);
    import crbt_pkg::*;

    logic [7:0] ctrl_reg;
    logic clkdiv_reg;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] capture_low_byte;
    logic [7:0] capture_high_byte;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [3:0] pre_reg;
    logic [2:0] cnt_sync_reg;
    logic [2:0] stb_sync_reg;
    logic cnt_lvl_reg;
    logic stb_lvl_reg;
    logic ack_reg;
    logic wreq_reg;
    logic [31:0] rdata_reg;
    crbt_evt_t evt_reg;
    logic irq_reg;

    crbt_mode_t mode;
    logic [15:0] count;
    logic [15:0] reload_val;
    logic cnt_fall;
    logic stb_fall;
    logic tick;
    logic wrap;
    logic stb_ev;
    logic wr_hit;
    logic [7:0] wbyte;

    assign count = {count_high_byte, count_low_byte}; // RQ1
    assign reload_val = {capture_high_byte, capture_low_byte};
    // Writes commit at the edge where the master sees waitrequest low,
    // so a master that aborts before then leaves no trace
    assign wr_hit = av_req_i.write && ack_reg;
    assign wbyte = av_req_i.writedata[7:0];

    // Mode decode
    always_comb begin
        if (!ctrl_reg[CRBT_B_RUN]) begin
            mode = CRBT_OFF; // RQ4 RQ11
        end else if (ctrl_reg[CRBT_B_RXSEL] || ctrl_reg[CRBT_B_TXSEL]) begin
            mode = CRBT_BAUD; // RQ4 RQ14
        end else if (ctrl_reg[CRBT_B_CPRL]) begin
            mode = CRBT_CAPTURE; // RQ5
        end else begin
            mode = CRBT_RELOAD; // RQ4
        end
    end

    // Pin synchronisers: edge seen once stages two and three agree
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cnt_sync_reg <= 3'h7;
            stb_sync_reg <= 3'h7;
            cnt_lvl_reg <= 1'b1;
            stb_lvl_reg <= 1'b1;
        end else if (ce_i) begin
            cnt_sync_reg <= {cnt_sync_reg[1:0], ext_count_pin_i}; // RQ19
            stb_sync_reg <= {stb_sync_reg[1:0], ext_strobe_pin_i}; // RQ19
            if (cnt_sync_reg[1] == cnt_sync_reg[2]) begin
                cnt_lvl_reg <= cnt_sync_reg[2];
            end
            if (stb_sync_reg[1] == stb_sync_reg[2]) begin
                stb_lvl_reg <= stb_sync_reg[2];
            end
        end
    end

    assign cnt_fall = cnt_lvl_reg && (cnt_sync_reg[2:1] == 2'b00); // RQ19
    assign stb_fall = stb_lvl_reg && (stb_sync_reg[2:1] == 2'b00); // RQ19
    // Strobe counts only with external enable and the timer running
    assign stb_ev = stb_fall && ctrl_reg[CRBT_B_EXEN] && mode != CRBT_OFF; // RQ7

    // Prescaler: /12 or /1 normally, /2 in baud mode
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            pre_reg <= 4'h0;
        end else if (ce_i) begin
            if (mode == CRBT_OFF || tick) begin
                pre_reg <= 4'h0;
            end else begin
                pre_reg <= pre_reg + 4'h1;
            end
        end
    end

    always_comb begin
        if (mode == CRBT_OFF) begin
            tick = 1'b0; // RQ11
        end else if (ctrl_reg[CRBT_B_CSRC]) begin
            tick = cnt_fall; // RQ2 RQ16
        end else if (mode == CRBT_BAUD) begin
            tick = pre_reg[0]; // RQ15
        end else if (clkdiv_reg) begin
            tick = 1'b1; // RQ2
        end else begin
            tick = (pre_reg == CRBT_DIV12_LAST); // RQ2
        end
    end

    assign wrap = tick && (count == CRBT_CNT_MAX);

    // Counter: software writes lose to hardware reload and increment
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            count_low_byte <= CRBT_RST_BYTE;
            count_high_byte <= CRBT_RST_BYTE;
        end else if (ce_i) begin
            if (wr_hit && av_req_i.address == CRBT_OFF_CNTL) begin
                count_low_byte <= wbyte;
            end
            if (wr_hit && av_req_i.address == CRBT_OFF_CNTH) begin
                count_high_byte <= wbyte;
            end
            if (mode != CRBT_CAPTURE && mode != CRBT_OFF
                && (wrap || (stb_ev && mode == CRBT_RELOAD))) begin
                // RQ9 RQ10 RQ12 RQ14
                {count_high_byte, count_low_byte} <= reload_val;
            end else if (tick) begin
                {count_high_byte, count_low_byte} <= count + 16'h0001; // RQ1
            end
        end
    end

    // Capture registers hold the reload value or the captured count
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            capture_low_byte <= CRBT_RST_BYTE;
            capture_high_byte <= CRBT_RST_BYTE;
        end else if (ce_i) begin
            if (stb_ev && mode == CRBT_CAPTURE) begin
                {capture_high_byte, capture_low_byte} <= count; // RQ6
            end else begin
                if (wr_hit && av_req_i.address == CRBT_OFF_CAPL) begin
                    capture_low_byte <= wbyte;
                end
                if (wr_hit && av_req_i.address == CRBT_OFF_CAPH) begin
                    capture_high_byte <= wbyte;
                end
            end
        end
    end

    // Control register; hardware flag set wins over software write
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CRBT_RST_BYTE;
            clkdiv_reg <= 1'b0;
        end else if (ce_i) begin
            if (wr_hit && av_req_i.address == CRBT_OFF_CTRL) begin
                ctrl_reg <= wbyte;
            end
            if (wr_hit && av_req_i.address == CRBT_OFF_CLKCTL) begin
                clkdiv_reg <= wbyte[CRBT_B_DIV];
            end
            if (wrap && (mode == CRBT_CAPTURE || mode == CRBT_RELOAD)) begin
                ctrl_reg[CRBT_B_OVF] <= 1'b1; // RQ8 RQ12
            end
            if (stb_ev) begin
                ctrl_reg[CRBT_B_EXF] <= 1'b1; // RQ6 RQ10 RQ17
            end
        end
    end

    // Interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            irq_stat_reg <= CRBT_RST_IRQ;
            irq_mask_reg <= CRBT_RST_IRQ;
        end else if (ce_i) begin
            if (wr_hit && av_req_i.address == CRBT_OFF_IRQ_MASK) begin
                irq_mask_reg <= av_req_i.writedata[2:0];
            end
            if (wr_hit && av_req_i.address == CRBT_OFF_IRQ_STAT) begin
                irq_stat_reg <= irq_stat_reg & ~av_req_i.writedata[2:0];
            end
            if (wrap && (mode == CRBT_CAPTURE || mode == CRBT_RELOAD)) begin
                irq_stat_reg[CRBT_I_OVF] <= 1'b1; // RQ8
            end
            if (stb_ev) begin
                irq_stat_reg[CRBT_I_EXF] <= 1'b1; // RQ6 RQ10 RQ17
            end
            if (wrap && mode == CRBT_BAUD) begin
                irq_stat_reg[CRBT_I_BAUD] <= 1'b1;
            end
        end
    end

    // Outputs: baud strobes per direction, converter trigger on wrap
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            evt_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce_i) begin
            evt_reg.rx_baud <= wrap && mode == CRBT_BAUD
                && ctrl_reg[CRBT_B_RXSEL]; // RQ12 RQ13
            evt_reg.tx_baud <= wrap && mode == CRBT_BAUD
                && ctrl_reg[CRBT_B_TXSEL]; // RQ12 RQ13
            evt_reg.adc_start <= wrap; // RQ3
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Avalon slave: one wait state, answer in second cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            ack_reg <= 1'b0;
            wreq_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else if (ce_i) begin
            ack_reg <= (av_req_i.read || av_req_i.write) && !ack_reg;
            // Own flop so the pin never carries an inverter glitch
            wreq_reg <= !((av_req_i.read || av_req_i.write) && !ack_reg);
            if (av_req_i.read && !ack_reg) begin
                unique case (av_req_i.address)
                    CRBT_OFF_CTRL: rdata_reg <= {24'h0, ctrl_reg};
                    CRBT_OFF_CLKCTL:
                        rdata_reg <= {26'h0, clkdiv_reg, 5'h00};
                    CRBT_OFF_CNTL: rdata_reg <= {24'h0, count_low_byte};
                    CRBT_OFF_CNTH: rdata_reg <= {24'h0, count_high_byte};
                    CRBT_OFF_CAPL: rdata_reg <= {24'h0, capture_low_byte};
                    CRBT_OFF_CAPH: rdata_reg <= {24'h0, capture_high_byte};
                    CRBT_OFF_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
                    CRBT_OFF_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
                    default: rdata_reg <= 32'h0;
                endcase
            end
        end
    end

    assign av_readdata_o = rdata_reg;
    assign av_waitrequest_o = wreq_reg;
    assign evt_o = evt_reg;
    assign irq_o = irq_reg;

    // Checks
    ovf_flag_set_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && wrap && (mode == CRBT_CAPTURE || mode == CRBT_RELOAD)
        |=> ctrl_reg[CRBT_B_OVF]) else $error("overflow flag not set"); // RQ8
    baud_no_flag_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && wrap && mode == CRBT_BAUD && !ctrl_reg[CRBT_B_OVF]
        && !(wr_hit && av_req_i.address == CRBT_OFF_CTRL)
        |=> !ctrl_reg[CRBT_B_OVF]) else $error("baud set flag"); // RQ12
    reload_on_wrap_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && wrap && mode == CRBT_RELOAD
        |=> count == $past(reload_val)) else $error("no reload"); // RQ9
    capture_copy_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && stb_ev && mode == CRBT_CAPTURE
        |=> reload_val == $past(count)) else $error("no capture"); // RQ6
    strobe_ignored_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && stb_fall && !ctrl_reg[CRBT_B_EXEN] && !ctrl_reg[CRBT_B_EXF]
        && !(wr_hit && av_req_i.address == CRBT_OFF_CTRL)
        |=> !ctrl_reg[CRBT_B_EXF]) else $error("strobe not ignored"); // RQ7
    stopped_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && !ctrl_reg[CRBT_B_RUN] && !wr_hit
        |=> $stable(count)) else $error("count moved while off"); // RQ11
    baud_div2_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && mode == CRBT_BAUD && !ctrl_reg[CRBT_B_CSRC] && tick
        |=> !tick) else $error("baud tick not halved"); // RQ15
    rx_baud_out_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && wrap && mode == CRBT_BAUD && ctrl_reg[CRBT_B_RXSEL]
        |=> evt_o.rx_baud && evt_o.adc_start)
        else $error("rx baud missing"); // RQ13
    edge_one_pulse_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ce_i && stb_fall |=> !stb_fall) else $error("double edge"); // RQ19

    // Strobe handling and interrupt level
    exf_flag_set_a: assert property (@(posedge clock_i) // RQ6
        disable iff (!rstn_i)
        ce_i && stb_ev |=> ctrl_reg[CRBT_B_EXF])
        else $error("external flag not set");
    strobe_reload_a: assert property (@(posedge clock_i) // RQ10
        disable iff (!rstn_i)
        ce_i && stb_ev && mode == CRBT_RELOAD
        |=> count == $past(reload_val))
        else $error("strobe reload missing");
    irq_high_a: assert property (@(posedge clock_i) // RQ8
        disable iff (!rstn_i)
        ce_i && |(irq_stat_reg & irq_mask_reg) |=> irq_o)
        else $error("interrupt not raised");
    irq_low_a: assert property (@(posedge clock_i) // RQ8
        disable iff (!rstn_i)
        ce_i && !(|(irq_stat_reg & irq_mask_reg)) |=> !irq_o)
        else $error("interrupt raised without cause");

    // Wrap behaviour per mode
    capture_wrap_a: assert property (@(posedge clock_i) // RQ8
        disable iff (!rstn_i)
        ce_i && wrap && mode == CRBT_CAPTURE |=> count == 16'h0000)
        else $error("capture wrap did not roll over");
    baud_reload_a: assert property (@(posedge clock_i) // RQ12
        disable iff (!rstn_i)
        ce_i && wrap && mode == CRBT_BAUD
        |=> count == $past(reload_val))
        else $error("baud reload missing");
    baud_no_irq_a: assert property (@(posedge clock_i) // RQ12
        disable iff (!rstn_i)
        ce_i && wrap && mode == CRBT_BAUD && !irq_stat_reg[CRBT_I_OVF]
        |=> !irq_stat_reg[CRBT_I_OVF])
        else $error("baud wrap set overflow status");
    tx_baud_out_a: assert property (@(posedge clock_i) // RQ13
        disable iff (!rstn_i)
        ce_i && wrap && mode == CRBT_BAUD && ctrl_reg[CRBT_B_TXSEL]
        |=> evt_o.tx_baud)
        else $error("tx baud missing");
    adc_trigger_a: assert property (@(posedge clock_i) // RQ3
        disable iff (!rstn_i)
        ce_i && wrap |=> evt_o.adc_start)
        else $error("converter trigger missing");

    // Counting source and mode decode
    count_step_a: assert property (@(posedge clock_i) // RQ1
        disable iff (!rstn_i)
        ce_i && tick && !wrap && !(stb_ev && mode == CRBT_RELOAD)
        |=> count == $past(count) + 16'h0001)
        else $error("count did not step");
    pin_source_a: assert property (@(posedge clock_i) // RQ16
        disable iff (!rstn_i)
        mode != CRBT_OFF && ctrl_reg[CRBT_B_CSRC] |-> tick == cnt_fall)
        else $error("pin source not followed");
    baud_decode_a: assert property (@(posedge clock_i) // RQ14
        disable iff (!rstn_i)
        ctrl_reg[CRBT_B_RUN]
        && (ctrl_reg[CRBT_B_RXSEL] || ctrl_reg[CRBT_B_TXSEL])
        |-> mode == CRBT_BAUD)
        else $error("baud mode not decoded");
    capture_decode_a: assert property (@(posedge clock_i) // RQ5
        disable iff (!rstn_i)
        ctrl_reg[CRBT_B_RUN] && ctrl_reg[CRBT_B_CPRL]
        && !ctrl_reg[CRBT_B_RXSEL] && !ctrl_reg[CRBT_B_TXSEL]
        |-> mode == CRBT_CAPTURE)
        else $error("capture mode not decoded");

    // Clock enable and bus handshake
    freeze_hold_a: assert property (@(posedge clock_i)
        disable iff (!rstn_i)
        !ce_i |=> $stable(count) && $stable(ctrl_reg))
        else $error("state moved while frozen");
    one_wait_a: assert property (@(posedge clock_i)
        disable iff (!rstn_i)
        ce_i && (av_req_i.read || av_req_i.write) && av_waitrequest_o
        |=> !av_waitrequest_o)
        else $error("bus answer late");

endmodule : crbt_timer

//--- crbt_pin_model.sv
// Far-side model driving the external count and strobe pins
`timescale 1ns/10ps
module crbt_pin_model (
    // Clock
    input wire logic clock_i,
    // Pins, idle high
    output logic count_pin_o,
    output logic strobe_pin_o
);
    initial begin
        count_pin_o = 1'b1;
        strobe_pin_o = 1'b1;
    end

    // Each level held 4 clocks so the 3-stage sampler sees every edge
    task automatic pulse(input bit strobe, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            if (strobe)
                strobe_pin_o <= 1'b0;
            else
                count_pin_o <= 1'b0;
            repeat (4) @(posedge clock_i);
            strobe_pin_o <= 1'b1;
            count_pin_o <= 1'b1;
            repeat (4) @(posedge clock_i);
        end
    endtask : pulse
endmodule : crbt_pin_model

//--- crbt_timer_test.sv
// Self-checking testbench of the capture/reload baud timer
`timescale 1ns/10ps
module crbt_timer_test;
    import crbt_pkg::*;
    logic clock_i, rstn_i, ce_i, irq_o, av_waitrequest_o;
    logic count_pin, strobe_pin;
    logic [31:0] av_readdata_o;
    crbt_avreq_t req;
    crbt_evt_t evt_o;
    int err_count, cmp_count;

    crbt_timer dut (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .av_req_i(req), .av_readdata_o(av_readdata_o),
        .av_waitrequest_o(av_waitrequest_o),
        .ext_count_pin_i(count_pin), .ext_strobe_pin_i(strobe_pin),
        .evt_o(evt_o), .irq_o(irq_o));
    crbt_pin_model pins (.clock_i(clock_i), .count_pin_o(count_pin),
        .strobe_pin_o(strobe_pin));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Idle edge first, so a release is never overwritten in the same step
    task automatic bus(input logic [3:0] a, input bit wr,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock_i);
        req.address <= a;
        req.write <= wr;
        req.read <= !wr;
        req.writedata <= {24'h0, d};
        do begin
            @(posedge clock_i);
            n++;
        end while (av_waitrequest_o !== 1'b0 && n < 50);
        q = av_readdata_o;
        if (n >= 50)
            err_count++;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 8'h0, q);
        check(q, exp);
    endtask : rdc

    task automatic wait_evt(input int idx, output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (evt_o[idx] !== 1'b1 && n < 2000);
    endtask : wait_evt

    task automatic t_reset();
        for (int a = 0; a < 8; a++)
            rdc(a[3:0], 32'h0);
        wr(4'h9, 8'h5a);
        rdc(4'h9, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_reload();
        logic [31:0] q;
        int n;
        wr(CRBT_OFF_CLKCTL, 8'h20);
        wr(CRBT_OFF_CAPL, 8'h34);
        wr(CRBT_OFF_CAPH, 8'h12);
        wr(CRBT_OFF_CNTL, 8'hf8);
        wr(CRBT_OFF_CNTH, 8'hff);
        wr(CRBT_OFF_IRQ_MASK, 8'h01);
        wr(CRBT_OFF_CTRL, 8'h04);
        n = 0;
        while (irq_o !== 1'b1 && n < 200) begin
            @(posedge clock_i);
            n++;
        end
        check(32'(n < 200), 32'h1);
        rdc(CRBT_OFF_CTRL, 32'h84);
        wr(CRBT_OFF_CTRL, 8'h00);
        rdc(CRBT_OFF_CNTH, 32'h12);
        bus(CRBT_OFF_CNTL, 1'b0, 8'h0, q);
        rdc(CRBT_OFF_CNTL, q);
        rdc(CRBT_OFF_IRQ_STAT, 32'h1);
        wr(CRBT_OFF_IRQ_STAT, 8'h01);
        rdc(CRBT_OFF_IRQ_STAT, 32'h0);
        check(32'(irq_o), 32'h0);
        $display("test reload done");
    endtask : t_reload

    task automatic t_capture();
        wr(CRBT_OFF_CAPL, 8'haa);
        wr(CRBT_OFF_CNTL, 8'h00);
        wr(CRBT_OFF_CNTH, 8'h00);
        wr(CRBT_OFF_IRQ_MASK, 8'h02);
        wr(CRBT_OFF_CTRL, 8'h07);
        pins.pulse(1'b0, 5);
        pins.pulse(1'b1, 1);
        rdc(CRBT_OFF_CAPL, 32'haa);
        rdc(CRBT_OFF_CNTL, 32'h05);
        wr(CRBT_OFF_CTRL, 8'h0f);
        pins.pulse(1'b1, 1);
        rdc(CRBT_OFF_CAPL, 32'h05);
        rdc(CRBT_OFF_CTRL, 32'h4f);
        rdc(CRBT_OFF_IRQ_STAT, 32'h2);
        check(32'(irq_o), 32'h1);
        wr(CRBT_OFF_IRQ_STAT, 8'h02);
        wr(CRBT_OFF_CAPL, 8'h40);
        wr(CRBT_OFF_CAPH, 8'h03);
        wr(CRBT_OFF_CTRL, 8'h0e);
        pins.pulse(1'b0, 3);
        pins.pulse(1'b1, 1);
        rdc(CRBT_OFF_CNTL, 32'h40);
        rdc(CRBT_OFF_CNTH, 32'h03);
        rdc(CRBT_OFF_IRQ_STAT, 32'h2);
        wr(CRBT_OFF_CTRL, 8'h00);
        wr(CRBT_OFF_IRQ_STAT, 8'h07);
        $display("test capture done");
    endtask : t_capture

    // Software keeps the baud mode for UART modes 1 and 3 only
    task automatic t_baud(input logic [7:0] sel, input int idx);
        int n;
        wr(CRBT_OFF_CAPL, 8'hf0);
        wr(CRBT_OFF_CAPH, 8'hff);
        wr(CRBT_OFF_CNTL, 8'hf0);
        wr(CRBT_OFF_CNTH, 8'hff);
        wr(CRBT_OFF_IRQ_MASK, 8'h00);
        wr(CRBT_OFF_CTRL, sel | 8'h0d);
        wait_evt(idx, n);
        wait_evt(idx, n);
        check(32'(n), 32'd32);
        check(32'(evt_o[0]), 32'h1);
        check(32'(evt_o[3 - idx]), 32'h0);
        rdc(CRBT_OFF_CTRL, 32'(sel | 8'h0d));
        rdc(CRBT_OFF_IRQ_STAT, 32'h4);
        check(32'(irq_o), 32'h0);
        pins.pulse(1'b1, 1);
        rdc(CRBT_OFF_CTRL, 32'(sel | 8'h4d));
        wr(CRBT_OFF_CTRL, 8'h00);
        wr(CRBT_OFF_IRQ_STAT, 8'h07);
        $display("test baud done");
    endtask : t_baud

    // Clock enable low must freeze the running counter
    task automatic t_freeze();
        wr(CRBT_OFF_CLKCTL, 8'h20);
        wr(CRBT_OFF_CNTL, 8'h00);
        wr(CRBT_OFF_CNTH, 8'h00);
        wr(CRBT_OFF_CTRL, 8'h04);
        ce_i <= 1'b0;
        repeat (20) @(posedge clock_i);
        ce_i <= 1'b1;
        wr(CRBT_OFF_CTRL, 8'h00);
        rdc(CRBT_OFF_CNTL, 32'h03);
        $display("test freeze done");
    endtask : t_freeze

    task automatic final_report();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (30000) @(posedge clock_i);
        err_count++;
        final_report();
    end

    initial begin
        err_count = 0;
        cmp_count = 0;
        rstn_i = 1'b0;
        ce_i = 1'b1;
        req = '0;
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_reset();
        t_reload();
        t_capture();
        t_baud(8'h20, 2);
        t_baud(8'h10, 1);
        t_freeze();
        final_report();
    end
endmodule : crbt_timer_test
